// ==== hw/pwr_otp_pkg.sv ====
// Purpose: shared constants and types for power-save and OTP sequencing
// Assumes: 100 MHz mclk_i, byte-wide command link
// Notes:   both ends import this package
//
// Operation
// - power-down flag set enters power save
// - hardware reset sets power-down flag
// - host waits discharge before cutting supply
// - power-down write alone enters power save
// - power-down cleared starts internal power-up
// - OTP cell burns only once
// - burned OTP value never readable by host
// - hardware reset after burn leaves test
// - host burn sequence with two delays
// - host contrast fine-tune byte sequence
// - OTP commands need test-enable flag first
// - 5-bit two's-complement offset counter wraps
`default_nettype none

package pwr_otp_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned DISCHARGE_MS    = 250;
  localparam int unsigned DISCHARGE_CYC   = DISCHARGE_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_LOW_NS      = 1500;
  localparam int unsigned RST_LOW_CYC     =
    (RST_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PWRUP_US        = 10;
  localparam int unsigned PWRUP_CYC       = PWRUP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DELAY_UNIT_US   = 1;
  localparam int unsigned DELAY_UNIT_CYC  =
    DELAY_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BURN_WAIT_LONG  = 1500;
  localparam int unsigned BURN_WAIT_SHORT = 750;

  // ------------------------------------------------------------------
  // command encodings
  // ------------------------------------------------------------------
  localparam logic [4:0] FSET_PAT     = 5'h04;
  localparam int         FSET_PD_BIT  = 2;
  localparam int         FSET_H_BIT   = 0;
  localparam logic [4:0] TEST_PAT     = 5'h06;
  localparam int         TEST_EN_BIT  = 0;
  localparam int         TSEL_LSB     = 1;
  localparam logic [1:0] TSEL_OSC     = 2'h0;
  localparam logic [1:0] TSEL_TRIM    = 2'h1;
  localparam logic [1:0] TSEL_OTP     = 2'h2;
  localparam logic [7:0] OSC_MASK     = 8'hfb;
  localparam logic [7:0] CMD_OSC      = 8'hb0;
  localparam int         OSC_BIT      = 2;
  localparam logic [7:0] CMD_V0_INC   = 8'h41;
  localparam logic [7:0] CMD_V0_DEC   = 8'h42;
  localparam logic [7:0] RDEN_MASK    = 8'hf7;
  localparam logic [7:0] CMD_RD_EN    = 8'h40;
  localparam int         XARD_BIT     = 3;
  localparam logic [7:0] CMD_CTRL_IN  = 8'h71;
  localparam logic [7:0] CMD_CTRL_OUT = 8'h88;
  localparam logic [7:0] CMD_WR_EN    = 8'h9f;
  localparam logic [7:0] CMD_WR       = 8'ha1;
  localparam logic [7:0] CMD_V0_ADDR  = 8'hc2;

  // ------------------------------------------------------------------
  // host sequences
  // ------------------------------------------------------------------
  localparam int unsigned SEQ_LEN = 10;
  localparam logic [7:0] BURN_SEQ [SEQ_LEN] = '{8'h20, 8'h08, 8'h21,
    8'h35, 8'h71, 8'hc2, 8'h9f, 8'ha1, 8'h88, 8'h30};
  localparam logic [7:0] TUNE_SEQ [SEQ_LEN] = '{8'h20, 8'h0c, 8'h21,
    8'h35, 8'h48, 8'h31, 8'hb4, 8'h33, 8'h41, 8'h30};
  localparam logic [3:0] BURN_LONG_IDX  = 4'h6;
  localparam logic [3:0] BURN_SHORT_IDX = 4'h7;
  localparam logic [3:0] TUNE_STEP_IDX  = 4'h8;

  // ------------------------------------------------------------------
  // widths, reset values, host registers
  // ------------------------------------------------------------------
  localparam int         OFS_W      = 5;
  localparam logic       PD_RST     = 1'b1;
  localparam logic [4:0] OFS_RST    = 5'h00;
  localparam int         APB_AW     = 4;
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_SEQ    = 4'h4;
  localparam logic [3:0] REG_CTRL   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam logic [1:0] SEQ_BURN   = 2'h1;
  localparam logic [1:0] SEQ_UP     = 2'h2;
  localparam logic [1:0] SEQ_DOWN   = 2'h3;

  typedef enum logic [1:0] {ST_SAVE, ST_PWRUP, ST_ON} pwr_state_t;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_RST} host_state_t;

endpackage : pwr_otp_pkg

`default_nettype wire

// ==== hw/pwr_otp_if.sv ====
// Purpose: command link between host and device
// Assumes: one byte per cycle when cmd_valid is high
// Notes:   hw_rst_n is the active-low hardware reset pin
`default_nettype none

interface pwr_otp_if;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       hw_rst_n;

  modport device (input cmd_valid, input cmd_byte, input hw_rst_n);
  modport host (output cmd_valid, output cmd_byte, output hw_rst_n);
endinterface : pwr_otp_if

`default_nettype wire

// ==== hw/otp_cell.sv ====
// Purpose: one-time programmable storage for the contrast offset
// Assumes: burn_i is a one-cycle pulse
// Notes:   rst_i stands for first power-up only (unprogrammed state)
`default_nettype none

module otp_cell #(
  parameter int W = 5
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         burn_i,
  input  wire logic [W-1:0] data_i,
  output logic              burned_o,
  output logic [W-1:0]      data_o
);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      burned_o <= 1'b0;
      data_o   <= '0;
    end else if (burn_i && !burned_o) begin
      burned_o <= 1'b1;
      data_o   <= data_i;
    end
  end

endmodule : otp_cell

`default_nettype wire

// ==== hw/lcd_pwr_device.sv ====
// Purpose: device end; power-save control and OTP command decode
// Assumes: link inputs synchronous to mclk_i
// Notes:   outputs all registered; no read path exists on the link
`default_nettype none

module lcd_pwr_device #(
  parameter int unsigned DISCHARGE_CYCLES = pwr_otp_pkg::DISCHARGE_CYC
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  pwr_otp_if.device                    link,
  output logic                         lcd_drive_gnd_o,
  output logic                         pump_en_o,
  output logic                         discharging_o,
  output logic                         discharge_done_o,
  output logic                         power_ready_o,
  output logic                         power_down_flag_o,
  output logic                         test_enable_flag_o,
  output logic                         osc_en_o,
  output logic [pwr_otp_pkg::OFS_W-1:0] contrast_offset_o,
  output logic                         otp_burned_o
);

  import pwr_otp_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    pwr_state_t       st;
    logic             power_down_flag;
    logic             ext_set;
    logic [1:0]       tsel;
    logic             test_enable_flag;
    logic             osc;
    logic             xard;
    logic             ctrl_in;
    logic             wr_en;
    logic             addr_v0;
    logic [OFS_W-1:0] contrast_offset_counter;
    logic [31:0]      cnt;
    logic             drive_gnd;
    logic             pump_en;
    logic             discharging;
    logic             discharged;
    logic             ready;
    logic             burn;
    logic [OFS_W-1:0] offset;
  } dev_state_t;

  dev_state_t       s;
  dev_state_t       next_s;
  logic [7:0]       cmd;
  logic             otp_burned;
  logic [OFS_W-1:0] otp_value;

  assign cmd = link.cmd_byte;

  // ------------------------------------------------------------------
  // one-time cell
  // ------------------------------------------------------------------
  otp_cell #(
    .W (OFS_W)
  ) i_otp_cell (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .burn_i   (s.burn),
    .data_i   (s.contrast_offset_counter),
    .burned_o (otp_burned),
    .data_o   (otp_value)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.burn = 1'b0;

    // power sequencing follows the registered flag
    case (s.st)
      ST_SAVE: begin
        if (!s.power_down_flag) begin
          next_s.st          = ST_PWRUP;
          next_s.cnt         = 32'(PWRUP_CYC);
          next_s.drive_gnd   = 1'b0;
          next_s.pump_en     = 1'b1;
          next_s.discharging = 1'b0;
          next_s.discharged  = 1'b0;
        end else if (s.cnt != 32'h0) begin
          next_s.cnt = s.cnt - 32'h1;
        end else begin
          next_s.discharging = 1'b0;
          next_s.discharged  = 1'b1;
        end
      end
      ST_PWRUP: begin
        if (s.power_down_flag) begin
          next_s.st = ST_SAVE;
        end else if (s.cnt == 32'h0) begin
          next_s.st    = ST_ON;
          next_s.ready = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 32'h1;
        end
      end
      ST_ON: begin
        if (s.power_down_flag) begin
          next_s.st = ST_SAVE;
        end
      end
      default: begin
        next_s.st = ST_SAVE;
      end
    endcase

    // entering save from any powered state starts a fresh discharge
    if (s.st != ST_SAVE && s.power_down_flag) begin
      next_s.st          = ST_SAVE;
      next_s.cnt         = 32'(DISCHARGE_CYCLES);
      next_s.drive_gnd   = 1'b1;
      next_s.pump_en     = 1'b0;
      next_s.discharging = 1'b1;
      next_s.discharged  = 1'b0;
      next_s.ready       = 1'b0;
    end

    // command decode
    if (link.cmd_valid) begin
      if (cmd[7:3] == FSET_PAT) begin
        next_s.power_down_flag = cmd[FSET_PD_BIT];
        next_s.ext_set         = cmd[FSET_H_BIT];
      end else if (s.ext_set && cmd[7:3] == TEST_PAT) begin
        next_s.tsel             = cmd[TSEL_LSB+1:TSEL_LSB];
        next_s.test_enable_flag = cmd[TEST_EN_BIT];
      end else if (s.test_enable_flag) begin
        case (s.tsel)
          TSEL_OSC: begin
            if ((cmd & OSC_MASK) == CMD_OSC) begin
              next_s.osc = cmd[OSC_BIT];
            end
          end
          TSEL_TRIM: begin
            // wraps silently; range guarding is left to software
            if (cmd == CMD_V0_INC) begin
              next_s.contrast_offset_counter =
                s.contrast_offset_counter + 5'h01;
            end else if (cmd == CMD_V0_DEC) begin
              next_s.contrast_offset_counter =
                s.contrast_offset_counter - 5'h01;
            end
          end
          TSEL_OTP: begin
            if ((cmd & RDEN_MASK) == CMD_RD_EN) begin
              next_s.xard = cmd[XARD_BIT];
            end else if (cmd == CMD_CTRL_IN) begin
              next_s.ctrl_in = 1'b1;
            end else if (cmd == CMD_CTRL_OUT) begin
              next_s.ctrl_in = 1'b0;
              next_s.wr_en   = 1'b0;
              next_s.addr_v0 = 1'b0;
            end else if (cmd == CMD_WR_EN) begin
              next_s.wr_en = 1'b1;
            end else if (cmd == CMD_V0_ADDR) begin
              next_s.addr_v0 = 1'b1;
            end else if (cmd == CMD_WR) begin
              next_s.burn = s.ctrl_in && s.wr_en && s.addr_v0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // auto-read picks the burned value once programmed
    next_s.offset = (otp_burned && !s.xard) ? otp_value
                                            : s.contrast_offset_counter;

    // hardware reset pin acts like a power-down write and ends test mode
    if (rst_i || !link.hw_rst_n) begin
      next_s                 = '0;
      next_s.st              = ST_SAVE;
      next_s.power_down_flag = PD_RST;
      next_s.test_enable_flag = 1'b0;
      next_s.contrast_offset_counter = OFS_RST;
      next_s.offset          = OFS_RST;
      next_s.cnt             = 32'(DISCHARGE_CYCLES);
      next_s.drive_gnd       = 1'b1;
      next_s.discharging     = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    s <= next_s;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // the burned value leaves only toward the analog side, never the link
  assign lcd_drive_gnd_o    = s.drive_gnd;
  assign pump_en_o          = s.pump_en;
  assign discharging_o      = s.discharging;
  assign discharge_done_o   = s.discharged;
  assign power_ready_o      = s.ready;
  assign power_down_flag_o  = s.power_down_flag;
  assign test_enable_flag_o = s.test_enable_flag;
  assign osc_en_o           = s.osc;
  assign contrast_offset_o  = s.offset;
  assign otp_burned_o       = otp_burned;

endmodule : lcd_pwr_device

`default_nettype wire

// ==== hw/lcd_pwr_host.sv ====
// Purpose: host end; APB-programmed command sender and sequencer
// Assumes: APB slave with no wait states beyond one access cycle
// Notes:   canned burn and trim sequences run from a built-in table
`default_nettype none

module lcd_pwr_host #(
  parameter int unsigned DISCHARGE_CYCLES  = pwr_otp_pkg::DISCHARGE_CYC,
  parameter int unsigned DELAY_UNIT_CYCLES = pwr_otp_pkg::DELAY_UNIT_CYC
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [pwr_otp_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           supply_en_o,
  pwr_otp_if.host                        link
);

  import pwr_otp_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [1:0]  kind;
    logic [3:0]  idx;
    logic [31:0] cnt;
    logic [31:0] disc;
    logic        pd;
    logic        supply_req;
    logic        supply_en;
    logic [7:0]  last_cmd;
    logic        cmd_valid;
    logic [7:0]  cmd_byte;
    logic        hw_rst_n;
    logic        pready;
    logic [31:0] prdata;
  } host_reg_t;

  host_reg_t s;
  host_reg_t next_s;
  logic      wr;
  logic [7:0] seq_b;

  function automatic logic [7:0] seq_byte(input logic [1:0] k,
                                          input logic [3:0] i);
    if (k == SEQ_BURN) begin
      seq_byte = BURN_SEQ[i];
    end else if (k == SEQ_DOWN && i == TUNE_STEP_IDX) begin
      seq_byte = CMD_V0_DEC;
    end else begin
      seq_byte = TUNE_SEQ[i];
    end
  endfunction : seq_byte

  assign wr    = psel_i && penable_i && s.pready && pwrite_i;
  assign seq_b = seq_byte(s.kind, s.idx);

  always_comb begin
    next_s           = s;
    next_s.cmd_valid = 1'b0;
    // pin idles high; only the reset-pulse state and rst_i pull it low
    next_s.hw_rst_n  = 1'b1;
    next_s.pready    = psel_i && !penable_i;
    if (psel_i && !penable_i) begin
      case (paddr_i)
        REG_CMD:    next_s.prdata = {24'h0, s.last_cmd};
        REG_CTRL:   next_s.prdata = {31'h0, s.supply_req};
        REG_STATUS: next_s.prdata = {28'h0, s.supply_en,
                                     s.pd && s.disc == 32'h0, s.pd,
                                     s.st != H_IDLE};
        default:    next_s.prdata = 32'h0;
      endcase
    end
    if (s.disc != 32'h0) begin
      next_s.disc = s.disc - 32'h1;
    end

    case (s.st)
      H_IDLE: begin
        if (wr && paddr_i == REG_CMD) begin
          next_s.cmd_valid = 1'b1;
          next_s.cmd_byte  = pwdata_i[7:0];
        end else if (wr && paddr_i == REG_SEQ && pwdata_i[1:0] != 2'h0) begin
          next_s.st   = H_SEND;
          next_s.kind = pwdata_i[1:0];
          next_s.idx  = 4'h0;
        end else if (wr && paddr_i == REG_CTRL && pwdata_i[1]) begin
          next_s.st  = H_RST;
          next_s.cnt = 32'(RST_LOW_CYC);
        end
      end
      H_SEND: begin
        next_s.cmd_valid = 1'b1;
        next_s.cmd_byte  = seq_b;
        next_s.idx       = s.idx + 4'h1;
        if (s.kind == SEQ_BURN && s.idx == BURN_LONG_IDX) begin
          next_s.st  = H_WAIT;
          next_s.cnt = 32'(BURN_WAIT_LONG * DELAY_UNIT_CYCLES);
        end else if (s.kind == SEQ_BURN && s.idx == BURN_SHORT_IDX) begin
          next_s.st  = H_WAIT;
          next_s.cnt = 32'(BURN_WAIT_SHORT * DELAY_UNIT_CYCLES);
        end else if (s.idx == 4'(SEQ_LEN - 1)) begin
          // a burn always ends with a reset pulse to drop test mode
          next_s.st  = (s.kind == SEQ_BURN) ? H_RST : H_IDLE;
          next_s.cnt = 32'(RST_LOW_CYC);
        end
      end
      H_WAIT: begin
        if (s.cnt <= 32'h1) begin
          next_s.st = H_SEND;
        end else begin
          next_s.cnt = s.cnt - 32'h1;
        end
      end
      H_RST: begin
        next_s.hw_rst_n = 1'b0;
        if (s.cnt <= 32'h1) begin
          next_s.st       = H_IDLE;
          next_s.hw_rst_n = 1'b1;
          next_s.pd       = 1'b1;
          next_s.disc     = 32'(DISCHARGE_CYCLES);
        end else begin
          next_s.cnt = s.cnt - 32'h1;
        end
      end
      default: next_s.st = H_IDLE;
    endcase

    if (next_s.cmd_valid && next_s.cmd_byte[7:3] == FSET_PAT) begin
      next_s.last_cmd = next_s.cmd_byte;
      next_s.pd       = next_s.cmd_byte[FSET_PD_BIT];
      if (next_s.cmd_byte[FSET_PD_BIT] && !s.pd) begin
        next_s.disc = 32'(DISCHARGE_CYCLES);
      end
    end else if (next_s.cmd_valid) begin
      next_s.last_cmd = next_s.cmd_byte;
    end
    if (wr && paddr_i == REG_CTRL) begin
      next_s.supply_req = pwdata_i[0];
    end
    // supply drops only once the discharge window has run out
    if (s.supply_req) begin
      next_s.supply_en = 1'b1;
    end else if (s.pd && s.disc == 32'h0) begin
      next_s.supply_en = 1'b0;
    end

    if (rst_i) begin
      next_s           = '0;
      next_s.st        = H_IDLE;
      next_s.hw_rst_n  = 1'b0;
      next_s.pd        = PD_RST;
      next_s.disc      = 32'(DISCHARGE_CYCLES);
      next_s.supply_req = 1'b1;
      next_s.supply_en = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    s <= next_s;
  end

  assign prdata_o       = s.prdata;
  assign pready_o       = s.pready;
  assign supply_en_o    = s.supply_en;
  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd_byte  = s.cmd_byte;
  assign link.hw_rst_n  = s.hw_rst_n;

endmodule : lcd_pwr_host

`default_nettype wire

// ==== sim/pwr_otp_monitor.sv ====
// Purpose: concurrent checks on the command link and power state
// Assumes: one clock domain, rst_i synchronous and active high
// Notes:   sits beside the link interface in tb_top, no bind
`default_nettype none

module pwr_otp_monitor
  import pwr_otp_pkg::*;
#(
  parameter int unsigned DISCHARGE_CYCLES = 200
) (
  input wire logic             mclk_i,
  input wire logic             rst_i,
  input wire logic             cmd_valid,
  input wire logic [7:0]       cmd_byte,
  input wire logic             hw_rst_n,
  input wire logic             lcd_drive_gnd_o,
  input wire logic             pump_en_o,
  input wire logic             discharging_o,
  input wire logic             discharge_done_o,
  input wire logic             power_ready_o,
  input wire logic             power_down_flag_o,
  input wire logic             test_enable_flag_o,
  input wire logic [OFS_W-1:0] contrast_offset_o,
  input wire logic             otp_burned_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // small slack on the timer: flag and state stages add a cycle or two
  localparam int DLO = DISCHARGE_CYCLES - 2;
  localparam int DHI = DISCHARGE_CYCLES + 4;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------------
  // power save
  // ------------------------------------------------------------------
  a_pd_enters_save: assert property (
    $rose(power_down_flag_o) && hw_rst_n |->
      ##1 (lcd_drive_gnd_o && !pump_en_o && discharging_o))
    else $error("save entry outputs wrong");
  a_save_holds_gnd: assert property (
    power_down_flag_o && $past(power_down_flag_o) |->
      lcd_drive_gnd_o && !pump_en_o)
    else $error("drive not grounded in save");
  a_discharge_bound: assert property (
    $rose(power_down_flag_o) && hw_rst_n |->
      ##[DLO:DHI] discharge_done_o)
    else $error("discharge timer off");
  a_hwrst_sets_pd: assert property (
    !hw_rst_n |=> power_down_flag_o && !test_enable_flag_o &&
      !power_ready_o)
    else $error("hardware reset left state");
  // cycles spent with the flag clear and power not yet ready
  logic [10:0] up_cyc;
  always_ff @(posedge mclk_i) begin
    if (rst_i || power_down_flag_o || power_ready_o) begin
      up_cyc <= 11'h000;
    end else if (up_cyc != 11'h7ff) begin
      up_cyc <= up_cyc + 11'h001;
    end
  end
  a_pd_clear_powers: assert property (
    up_cyc <= 11'(PWRUP_CYC + 10))
    else $error("power-up did not finish");

  // ------------------------------------------------------------------
  // otp
  // ------------------------------------------------------------------
  a_otp_once: assert property (
    otp_burned_o |=> otp_burned_o)
    else $error("burned mark lost");
  a_ten_gates_offset: assert property (
    // the cycle after a reset ends may load the burned value
    !test_enable_flag_o && hw_rst_n && $past(hw_rst_n) |=>
      $stable(contrast_offset_o))
    else $error("offset moved outside test mode");
  a_burn_needs_cmd: assert property (
    $rose(otp_burned_o) |-> $past(cmd_valid && cmd_byte == CMD_WR, 2))
    else $error("burn without write command");
  a_burn_needs_ten: assert property (
    $rose(otp_burned_o) |-> $past(test_enable_flag_o, 2))
    else $error("burn without test enable");

endmodule : pwr_otp_monitor

`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench joining host and device ends
// Assumes: shortened discharge and delay unit counts
// Notes:   random trim directions from a fixed seed
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pwr_otp_pkg::*;

  localparam int unsigned DIS = 200;
  logic        mclk_i, rst_i, psel, penable, pwrite, pready, supply_en;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        drive_gnd, pump_en, dis_run, dis_done, pwr_ready;
  logic        pd_flag, ten_flag, osc_en, burned;
  logic [4:0]  offset;
  int          num_errors, n_tests, seed;

  pwr_otp_if link_if ();

  lcd_pwr_host #(.DISCHARGE_CYCLES(DIS), .DELAY_UNIT_CYCLES(1))
  i_lcd_pwr_host (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .supply_en_o(supply_en), .link(link_if));

  lcd_pwr_device #(.DISCHARGE_CYCLES(DIS)) i_lcd_pwr_device (
    .mclk_i(mclk_i), .rst_i(rst_i), .link(link_if),
    .lcd_drive_gnd_o(drive_gnd), .pump_en_o(pump_en),
    .discharging_o(dis_run), .discharge_done_o(dis_done),
    .power_ready_o(pwr_ready), .power_down_flag_o(pd_flag),
    .test_enable_flag_o(ten_flag), .osc_en_o(osc_en),
    .contrast_offset_o(offset), .otp_burned_o(burned));

  pwr_otp_monitor #(.DISCHARGE_CYCLES(DIS)) i_pwr_otp_monitor (
    .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid(link_if.cmd_valid),
    .cmd_byte(link_if.cmd_byte), .hw_rst_n(link_if.hw_rst_n),
    .lcd_drive_gnd_o(drive_gnd), .pump_en_o(pump_en),
    .discharging_o(dis_run), .discharge_done_o(dis_done),
    .power_ready_o(pwr_ready), .power_down_flag_o(pd_flag),
    .test_enable_flag_o(ten_flag), .contrast_offset_o(offset),
    .otp_burned_o(burned));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [4:0] step(logic [4:0] v, logic up);
    return up ? v + 5'h01 : v - 5'h01;
  endfunction : step

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // holds the request until pready is seen high at a rising edge, giving up after 100 edges
  task automatic apb(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    if (q[0] !== 1'b0) chk("busy", 32'h0, 32'h1);
  endtask : wait_idle

  task automatic send(input logic [7:0] b);
    logic [31:0] q;
    apb(1'b1, REG_CMD, {24'h0, b}, q);
    wait_idle();
  endtask : send

  task automatic run_seq(input logic [1:0] s);
    logic [31:0] q;
    apb(1'b1, REG_SEQ, {30'h0, s}, q);
    wait_idle();
  endtask : run_seq

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (60000) @(posedge mclk_i);
    num_errors++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin : main
    logic [31:0] q;
    logic [4:0]  cnt, first;
    logic        up;
    int          k;
    seed = 32'h4e67;
    num_errors = 0;
    n_tests = 0;
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk("pd_after_reset", 32'h1, {31'h0, pd_flag});
    chk("gnd_after_reset", 32'h1, {31'h0, drive_gnd});
    apb(1'b0, REG_STATUS, 32'h0, q);
    chk("status_reset", 32'ha, q & 32'hb);
    apb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped_read", 32'h0, q);
    send(CMD_V0_INC);
    chk("ofs_no_ten", 32'h0, {27'h0, offset});
    send(8'h20);
    for (k = 0; k < 1100 && pwr_ready !== 1'b1; k++) @(posedge mclk_i);
    chk("ready", 32'h1, {31'h0, pwr_ready});
    chk("pump_on", 32'h1, {31'h0, pump_en});
    send(8'h24);
    chk("gnd_save", 32'h1, {31'h0, drive_gnd});
    chk("pump_save", 32'h0, {31'h0, pump_en});
    repeat (DIS + 10) @(posedge mclk_i);
    apb(1'b0, REG_STATUS, 32'h0, q);
    chk("elapsed", 32'h6, q & 32'h6);
    chk("dis_done", 32'h1, {31'h0, dis_done});
    chk("dis_run", 32'h0, {31'h0, dis_run});
    apb(1'b1, REG_CTRL, 32'h0, q);
    repeat (3) @(posedge mclk_i);
    chk("supply_off", 32'h0, {31'h0, supply_en});
    apb(1'b1, REG_CTRL, 32'h1, q);
    send(8'h21);
    send(8'h33);
    chk("ten_set", 32'h1, {31'h0, ten_flag});
    apb(1'b1, REG_CTRL, 32'h3, q);
    wait_idle();
    chk("ten_hw_rst", 32'h0, {31'h0, ten_flag});
    chk("pd_hw_rst", 32'h1, {31'h0, pd_flag});
    // sixteen ups first so the count crosses +15 into -16
    cnt = 5'h00;
    for (k = 0; k < 24; k++) begin
      up = (k < 16) ? 1'b1 : 1'($random(seed));
      run_seq(up ? SEQ_UP : SEQ_DOWN);
      cnt = step(cnt, up);
      chk("offset", {27'h0, cnt}, {27'h0, offset});
    end
    chk("ten_after_trim", 32'h0, {31'h0, ten_flag});
    chk("osc_on", 32'h1, {31'h0, osc_en});
    first = cnt;
    run_seq(SEQ_BURN);
    chk("burned", 32'h1, {31'h0, burned});
    chk("ten_after_burn", 32'h0, {31'h0, ten_flag});
    chk("otp_value", {27'h0, first}, {27'h0, offset});
    apb(1'b0, REG_CMD, 32'h0, q);
    chk("no_read_path", 32'h30, q & 32'hff);
    // counter now differs from the stored value; a second burn must not land
    run_seq(SEQ_DOWN);
    run_seq(SEQ_BURN);
    chk("otp_kept", {27'h0, first}, {27'h0, offset});
    end_of_test();
  end

endmodule : tb_top

`default_nettype wire
